// ### logic/sdrc_pkg.sv
// shared constants and types for the sampling delay ramp control block
package sdrc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;                        // REF_CLK period
  localparam int CAL_SETTLE_NS = 3200;                       // settle time per search step
  localparam int CAL_SETTLE_CYC = (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // delay ramp
  // ****************************************************************
  localparam int RAMP_WINDOW = 256;                          // cycles per ramp window
  localparam int RAMP_FAST_STEPS = 4;                        // steps per window, fast rate
  localparam logic [7:0] RAMP_SLOW_LAST = 8'(RAMP_WINDOW - 1);
  localparam logic [7:0] RAMP_FAST_LAST = 8'(RAMP_WINDOW / RAMP_FAST_STEPS - 1);
  localparam logic [7:0] DLY_MAX = 8'hFF;                    // top of 256 settings

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;                  // mode, invert, ramp, fine
  localparam logic [3:0] REG_COARSE = 4'h4;                  // coarse target
  localparam logic [3:0] REG_STATUS = 4'h8;                  // applied state, flags
  localparam logic [3:0] REG_CAL    = 4'hC;                  // calibration start

  // field positions
  localparam int CTRL_SINGLE = 0;                            // single-channel mode
  localparam int CTRL_INV    = 1;                            // clock_invert_delay
  localparam int CTRL_RAMPEN = 2;                            // delay_ramp_enable
  localparam int CTRL_FAST   = 3;                            // delay_ramp_speed_select
  localparam int CTRL_FINE   = 8;                            // fine_delay_setting lsb
  localparam int ST_BUSY     = 8;                            // ramp in progress
  localparam int ST_DONE     = 9;                            // calibration_done_flag
  localparam int ST_CALBUSY  = 10;                           // calibration running
  localparam int ST_SEEN     = 11;                           // timing reference captured
  localparam int CAL_START   = 0;                            // start bit

  // reset values
  localparam logic [7:0] FINE_RST   = 8'h00;
  localparam logic [7:0] COARSE_RST = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic       inv;                                         // half-period inversion
    logic [7:0] coarse;                                      // applied coarse setting
    logic [7:0] fine;                                        // applied fine setting
  } sdrc_dly_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_CHECK} sdrc_cal_t;

endpackage

// ### logic/sdrc_ramp.sv
// coarse delay stepper that walks the applied setting toward a target
`timescale 1ns/10ps
`default_nettype none
module sdrc_ramp
  import sdrc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       wr,
  input  wire logic [7:0] wr_val,
  input  wire logic       ramp_en,
  input  wire logic       fast,
  input  wire logic       force_en,
  input  wire logic [7:0] force_val,
  output logic      [7:0] cur,
  output logic            busy
);

  // state of the stepper
  typedef struct packed {
    logic [7:0] cur;                                         // applied coarse
    logic [7:0] tgt;                                         // ramp target
    logic [7:0] tmr;                                         // window timer
    logic       busy;                                        // ramp active
  } sdrc_ramp_st_t;

  sdrc_ramp_st_t s_r;
  sdrc_ramp_st_t s_nxt;
  logic [7:0]    last;                                       // last timer value of a step

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    last  = fast ? RAMP_FAST_LAST : RAMP_SLOW_LAST;          // RULE_10
    if (force_en)
    begin
      // calibration owns the path: load at once
      s_nxt.cur  = force_val;
      s_nxt.tgt  = force_val;
      s_nxt.tmr  = '0;
      s_nxt.busy = 1'b0;
    end
    else if (wr && ramp_en)
    begin
      // a new write restarts the walk toward the new target
      s_nxt.tgt  = wr_val;                                   // RULE_11
      s_nxt.tmr  = '0;
      s_nxt.busy = (wr_val != s_r.cur);
    end
    else if (wr)
    begin
      // ramp off: jump straight to the written value
      s_nxt.cur  = wr_val;                                   // RULE_13
      s_nxt.tgt  = wr_val;
      s_nxt.busy = 1'b0;
    end
    else if (s_r.busy)
    begin
      if (s_r.tmr == last)
      begin
        // one step per timer window, either direction
        s_nxt.tmr  = '0;
        s_nxt.cur  = (s_r.cur < s_r.tgt) ? s_r.cur + 8'h01 : s_r.cur - 8'h01; // RULE_09
        s_nxt.busy = (s_nxt.cur != s_r.tgt);                 // RULE_13
      end
      else
      begin
        s_nxt.tmr = s_r.tmr + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_r <= '{cur: COARSE_RST, tgt: COARSE_RST, tmr: 8'h00, busy: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign cur  = s_r.cur;
  assign busy = s_r.busy;

  // ****************************************************************
  // checks
  // ****************************************************************
  ramp_hold_a : assert property (@(posedge clk) disable iff (!rstn) // RULE_10
    s_r.busy && !force_en && !wr && (s_r.tmr != last) |=> $stable(s_r.cur))
    else $error("coarse moved inside a ramp window");

  ramp_step_a : assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    s_r.busy && !force_en && !wr |=> (s_r.cur == $past(s_r.cur))
      || (s_r.cur == $past(s_r.cur) + 8'h01) || (s_r.cur == $past(s_r.cur) - 8'h01))
    else $error("ramp jumped more than one step");

  ramp_stop_a : assert property (@(posedge clk) disable iff (!rstn) // RULE_13
    s_r.busy |-> s_r.cur != s_r.tgt)
    else $error("ramp still busy at target");

endmodule
`default_nettype wire

// ### logic/sdrc_top.sv
// sampling delay ramp control: wishbone registers, reference capture, calibration
// Notes on behaviour
// [RULE_01] dual mode rising edge; single mode both edges
// [RULE_02] timing reference captured at fixed clock edge
// [RULE_03] periodic reference rate set by link format
// [RULE_04] invert bit adds half-period delay
// [RULE_05] coarse and fine each have 256 settings
// [RULE_06] invert, coarse, fine applied together, summed
// [RULE_07] applied delay shifts every internal clock
// [RULE_08] live delay changes may upset link
// [RULE_09] ramp walks coarse stepwise toward target
// [RULE_10] rate select: one or four steps per 256
// [RULE_11] with ramp enabled each coarse write restarts
// [RULE_12] calibration searches delay, then raises done flag
// [RULE_13] no ramp jumps at once; ramp stops at target
`timescale 1ns/10ps
`default_nettype none
module sdrc_top
  import sdrc_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        TREF_IN,
  input  wire logic        CAL_EDGE_AHEAD,
  output logic             TREF_CAPT,
  output logic             SAMPLE_RISE_EN,
  output logic             SAMPLE_FALL_EN,
  output logic             DLY_INV,
  output logic      [7:0]  DLY_COARSE,
  output logic      [7:0]  DLY_FINE,
  output logic             LINK_UPSET
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        ack;                                        // bus acknowledge
    logic [31:0] rdata;                                      // read data
    logic        single;                                     // single-channel mode
    logic        inv;                                        // clock_invert_delay
    logic        ramp_en;                                    // delay_ramp_enable
    logic        fast;                                       // delay_ramp_speed_select
    logic [7:0]  fine;                                       // fine_delay_setting
    logic [7:0]  coarse;                                     // coarse_delay_setting
    logic        coarse_wr;                                  // coarse write pulse
    logic [1:0]  s1;                                         // pin sync stage 1
    logic [1:0]  s2;                                         // pin sync stage 2
    logic [1:0]  s3;                                         // pin sync stage 3
    logic [1:0]  filt;                                       // agreed pin levels
    logic        capt;                                       // reference capture pulse
    logic        seen;                                       // reference seen, sticky
    logic        upset;                                      // delay changed pulse
    sdrc_cal_t   cal;                                        // calibration state
    logic [7:0]  cal_cnt;                                    // settle counter
    logic [7:0]  cal_coarse;                                 // search position
    logic        cal_ref;                                    // phase at first check
    logic        cal_first;                                  // first check pending
    logic        done;                                       // calibration_done_flag
    sdrc_dly_t   dly;                                        // applied delay
    logic        rise;                                       // rising-edge sampling
    logic        fall;                                       // falling-edge sampling
  } sdrc_st_t;

  localparam int PIN_TREF = 0;                               // timing reference bit
  localparam int PIN_PH   = 1;                               // phase comparator bit
  localparam logic [7:0] SETTLE_LAST = 8'(CAL_SETTLE_CYC - 1);

  sdrc_st_t   st_r;                                          // registered state
  sdrc_st_t   st_nxt;                                        // next state
  logic [7:0] ramp_cur;                                      // stepper output
  logic       ramp_busy;                                     // stepper active
  logic       bus_req;                                       // request pending
  logic       bus_wr;                                        // write takes effect
  logic       cal_on;                                        // calibration owns path

  // ****************************************************************
  // helpers
  // ****************************************************************
  // byte-lane merge of write data into a 32-bit register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    end
    return r;
  endfunction

  // register image of the control word
  function automatic logic [31:0] ctrl_img(input sdrc_st_t s);
    logic [31:0] r;
    r = '0;
    r[CTRL_SINGLE] = s.single;
    r[CTRL_INV] = s.inv;
    r[CTRL_RAMPEN] = s.ramp_en;
    r[CTRL_FAST] = s.fast;
    r[CTRL_FINE +: 8] = s.fine;
    return r;
  endfunction

  // ****************************************************************
  // coarse stepper
  // ****************************************************************
  assign cal_on = (st_r.cal != CAL_IDLE);

  sdrc_ramp u_ramp (
    .clk       (REF_CLK),
    .rstn      (RSTN),
    .wr        (st_r.coarse_wr),
    .wr_val    (st_r.coarse),
    .ramp_en   (st_r.ramp_en),
    .fast      (st_r.fast),
    .force_en  (cal_on),
    .force_val (st_r.cal_coarse),
    .cur       (ramp_cur),
    .busy      (ramp_busy)
  );

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    logic [31:0] img;
    img     = '0;
    st_nxt  = st_r;
    bus_req = WB_CYC_I && WB_STB_I;
    // write lands on the edge where the master sees ack
    bus_wr  = bus_req && WB_WE_I && st_r.ack;

    // bus: ack one cycle after request, dropped the cycle after
    st_nxt.ack = bus_req && !st_r.ack;
    st_nxt.coarse_wr = 1'b0;
    if (bus_req && !st_r.ack)
    begin
      // read mux; unmapped offsets read zero
      unique case (WB_ADR_I)
        REG_CTRL:   st_nxt.rdata = ctrl_img(st_r);
        REG_COARSE: st_nxt.rdata = {24'h000000, st_r.coarse};
        REG_STATUS:
        begin
          img = {24'h000000, st_r.dly.coarse};
          img[ST_BUSY] = ramp_busy;
          img[ST_DONE] = st_r.done;
          img[ST_CALBUSY] = cal_on;
          img[ST_SEEN] = st_r.seen;
          st_nxt.rdata = img;
        end
        default:    st_nxt.rdata = '0;
      endcase
    end

    // register writes
    if (bus_wr && (WB_ADR_I == REG_CTRL))
    begin
      img = lane_merge(ctrl_img(st_r), WB_DAT_I, WB_SEL_I);
      st_nxt.single = img[CTRL_SINGLE];
      st_nxt.inv = img[CTRL_INV];
      st_nxt.ramp_en = img[CTRL_RAMPEN];
      st_nxt.fast = img[CTRL_FAST];
      st_nxt.fine = img[CTRL_FINE +: 8];                     // RULE_05
    end
    if (bus_wr && (WB_ADR_I == REG_COARSE) && WB_SEL_I[0])
    begin
      // every coarse write is handed to the stepper
      st_nxt.coarse = WB_DAT_I[7:0];                         // RULE_11
      st_nxt.coarse_wr = 1'b1;
    end

    // pin synchronisers: three stages, level moves when 2 and 3 agree
    st_nxt.s1 = {CAL_EDGE_AHEAD, TREF_IN};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 2; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.filt[i] = st_r.s3[i];
    end

    // reference capture: fixed number of edges from the pin, every start
    st_nxt.capt = st_nxt.filt[PIN_TREF] && !st_r.filt[PIN_TREF]; // RULE_02
    // seen flag: set wins over a status write clear
    if (bus_wr && (WB_ADR_I == REG_STATUS) && WB_SEL_I[1] && WB_DAT_I[ST_SEEN])
      st_nxt.seen = 1'b0;
    if (st_nxt.capt)
      st_nxt.seen = 1'b1;

    // calibration search on the shared delay path
    unique case (st_r.cal)
      CAL_IDLE:
      begin
        if (bus_wr && (WB_ADR_I == REG_CAL) && WB_SEL_I[0] && WB_DAT_I[CAL_START])
        begin
          st_nxt.cal = CAL_SETTLE;
          st_nxt.cal_coarse = COARSE_RST;
          st_nxt.cal_cnt = '0;
          st_nxt.cal_first = 1'b1;
          st_nxt.done = 1'b0;
        end
      end
      CAL_SETTLE:
      begin
        // wait for the shifted clock and a periodic reference to settle
        st_nxt.cal_cnt = st_r.cal_cnt + 8'h01;               // RULE_03
        if (st_r.cal_cnt == SETTLE_LAST)
          st_nxt.cal = CAL_CHECK;
      end
      CAL_CHECK:
      begin
        st_nxt.cal_first = 1'b0;
        st_nxt.cal_cnt = '0;
        if (st_r.cal_first)
        begin
          st_nxt.cal_ref = st_r.filt[PIN_PH];
          st_nxt.cal = CAL_SETTLE;
        end
        else if ((st_r.filt[PIN_PH] != st_r.cal_ref) || (st_r.cal_coarse == DLY_MAX))
        begin
          // falling edge now lines up with the reference edge, or the coarse search reached DLY_MAX
          st_nxt.cal = CAL_IDLE;                             // RULE_12
          st_nxt.done = 1'b1;
          st_nxt.coarse = st_r.cal_coarse;
        end
        else
        begin
          st_nxt.cal_coarse = st_r.cal_coarse + 8'h01;
          st_nxt.cal = CAL_SETTLE;
        end
      end
    endcase

    // applied delay: three independent parts, moved as one word
    st_nxt.dly.inv = st_r.inv;                               // RULE_04
    st_nxt.dly.coarse = ramp_cur;                            // RULE_06
    st_nxt.dly.fine = st_r.fine;
    // any change shifts every derived clock; flag the link hazard
    st_nxt.upset = (st_nxt.dly != st_r.dly);                 // RULE_08

    // sampling edges per channel mode
    st_nxt.rise = 1'b1;                                      // RULE_01
    st_nxt.fall = st_r.single;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      st_r <= '0;
      st_r.cal <= CAL_IDLE;
      st_r.fine <= FINE_RST;
      st_r.coarse <= COARSE_RST;
      st_r.dly <= '{inv: 1'b0, coarse: COARSE_RST, fine: FINE_RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs, all straight from state flops
  // ****************************************************************
  assign WB_DAT_O       = st_r.rdata;
  assign WB_ACK_O       = st_r.ack;
  assign TREF_CAPT      = st_r.capt;
  assign SAMPLE_RISE_EN = st_r.rise;
  assign SAMPLE_FALL_EN = st_r.fall;
  // the delay word feeds the root of the clock tree, so lanes and capture move too
  assign DLY_INV        = st_r.dly.inv;                      // RULE_07
  assign DLY_COARSE     = st_r.dly.coarse;
  assign DLY_FINE       = st_r.dly.fine;
  assign LINK_UPSET     = st_r.upset;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence ctrl_write_s;
    bus_wr && (WB_ADR_I == REG_CTRL) && WB_SEL_I[0];
  endsequence

  sequence tref_rise_s;
    $rose(st_r.filt[PIN_TREF]);
  endsequence

  bus_ack_a : assert property (
    bus_req && !st_r.ack |=> st_r.ack ##1 !st_r.ack)
    else $error("bus ack not a single pulse after request");

  sample_edges_a : assert property ( // RULE_01
    ctrl_write_s |-> ##2 SAMPLE_RISE_EN && (SAMPLE_FALL_EN == $past(WB_DAT_I[CTRL_SINGLE], 2)))
    else $error("sampling edges do not follow channel mode");

  tref_capt_a : assert property ( // RULE_02
    tref_rise_s |-> TREF_CAPT ##1 !TREF_CAPT)
    else $error("reference capture not on fixed edge");

  invert_path_a : assert property ( // RULE_04
    ctrl_write_s |-> ##2 DLY_INV == $past(WB_DAT_I[CTRL_INV], 2))
    else $error("invert not applied two edges after write");

  fine_path_a : assert property ( // RULE_05
    bus_wr && (WB_ADR_I == REG_CTRL) && WB_SEL_I[1]
      |-> ##2 DLY_FINE == $past(WB_DAT_I[CTRL_FINE +: 8], 2))
    else $error("fine setting not applied");

  coarse_now_a : assert property ( // RULE_13
    bus_wr && (WB_ADR_I == REG_COARSE) && WB_SEL_I[0] && !st_r.ramp_en && !cal_on
      ##1 !cal_on |-> ##2 DLY_COARSE == $past(WB_DAT_I[7:0], 3))
    else $error("coarse write without ramp not immediate");

  summed_dly_a : assert property ( // RULE_06
    1'b1 |=> DLY_COARSE == $past(ramp_cur) && DLY_FINE == $past(st_r.fine)
      && DLY_INV == $past(st_r.inv))
    else $error("delay parts not applied together");

  upset_flag_a : assert property ( // RULE_08
    $changed(st_r.dly) |-> LINK_UPSET)
    else $error("delay change not flagged");

  cal_done_a : assert property ( // RULE_12
    st_r.cal == CAL_CHECK && !st_r.cal_first && (st_r.filt[PIN_PH] != st_r.cal_ref)
      |=> st_r.done && st_r.cal == CAL_IDLE)
    else $error("calibration did not finish on phase flip");

  cal_force_a : assert property ( // RULE_12
    cal_on |=> ramp_cur == $past(st_r.cal_coarse))
    else $error("calibration does not drive delay path");

endmodule
`default_nettype wire

// ### verif/sdrc_src.sv
// model of the external clock source: timing reference and phase comparator
`timescale 1ns/10ps
`default_nettype none
module sdrc_src
  import sdrc_pkg::*;
#(
  parameter logic [7:0] EDGE_AT = 8'h03          // coarse step where edges line up
)(
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [7:0] coarse,
  output logic            tref,
  output logic            ahead
);
  logic [1:0] cnt_r = 2'h0;                      // pulse length counter, idle at start
  // ****************************************
  // single reference pulse, three cycles wide
  // ****************************************
  always @(posedge clk)
  begin
    if (fire)
      cnt_r <= 2'h3;
    else if (cnt_r != 2'h0)
      cnt_r <= cnt_r - 2'h1;
  end
  assign tref = (cnt_r != 2'h0);
  // the delayed clock edge passes the reference once coarse reaches EDGE_AT
  assign ahead = (coarse >= EDGE_AT);
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the sampling delay ramp control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sdrc_pkg::*;
();
  logic clk, rstn, cyc, stb, we, fire, tref, ahead, ack, capt, rise, fall, inv, upset;
  logic [3:0]  adr, sel;
  logic [31:0] dat_i, dat_o, q;
  logic [7:0]  coarse, fine;
  int          fails, n_tests, n_up, n_capt, b;
  sdrc_top uut (.REF_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .TREF_IN(tref), .CAL_EDGE_AHEAD(ahead), .TREF_CAPT(capt), .SAMPLE_RISE_EN(rise),
    .SAMPLE_FALL_EN(fall), .DLY_INV(inv), .DLY_COARSE(coarse), .DLY_FINE(fine),
    .LINK_UPSET(upset));
  sdrc_src #(.EDGE_AT(8'h03)) src (.clk(clk), .fire(fire), .coarse(coarse), .tref(tref),
    .ahead(ahead));
  // ****************************************
  // clock, pulse counters, helpers
  // ****************************************
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    if (upset === 1'b1)
      n_up <= n_up + 1;
    if (capt === 1'b1)
      n_capt <= n_capt + 1;
  end
  function automatic logic [31:0] dly();
    return {13'h0, rise, fall, inv, coarse, fine};
  endfunction
  task automatic w8(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat_i <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    // a bus cycle that never sees ack counts against the run
    if (ack !== 1'b1)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ack, 1'b1);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ctrl();
    chk(dly(), 32'h00040000);
    b = n_up;
    wb(1'b1, REG_CTRL, 32'h0000A503);
    w8(3);
    chk(dly(), 32'h000700A5);
    chk(n_up - b, 1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0000A503);
    wb(1'b1, REG_COARSE, 32'hFF);
    w8(4);
    chk(dly(), 32'h0007FFA5);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("test ctrl done");
  endtask
  task automatic t_ramp();
    wb(1'b1, REG_CTRL, 32'h0000A506);
    wb(1'b1, REG_COARSE, 32'hFD);
    w8(200);
    chk(coarse, 8'hFF);
    w8(70);
    chk(coarse, 8'hFE);
    w8(260);
    chk(coarse, 8'hFD);
    w8(300);
    chk(coarse, 8'hFD);
    wb(1'b1, REG_CTRL, 32'h0000A50E);
    wb(1'b1, REG_COARSE, 32'hF0);
    w8(137);
    chk(coarse, 8'hFB);
    wb(1'b1, REG_COARSE, 32'hFF);
    w8(137);
    chk(coarse, 8'hFD);
    w8(140);
    chk(coarse, 8'hFF);
    $display("test ramp done");
  endtask
  task automatic t_tref();
    b = n_capt;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    w8(10);
    chk(n_capt - b, 1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[ST_SEEN], 1'b1);
    wb(1'b1, REG_STATUS, 32'h00000800);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[ST_SEEN], 1'b0);
    $display("test tref done");
  endtask
  task automatic t_cal();
    int n;
    n = 0;
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b1, REG_CAL, 32'h1);
    q = 32'h0;
    while (q[ST_DONE] !== 1'b1 && n < 100)
    begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    chk(q[ST_DONE], 1'b1);
    chk(q[7:0], 8'h03);
    chk(dly(), 32'h00040300);
    $display("test cal done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    {clk, cyc, stb, we, fire, adr, sel, dat_i} = '0;
    sel = 4'hF;
    {fails, n_tests, n_up, n_capt} = '0;
    rstn = 1'b0;
    w8(10);
    rstn <= 1'b1;
    w8(2);
    t_ctrl();
    t_ramp();
    t_tref();
    t_cal();
    close_out();
  end
  initial
  begin
    w8(20000);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
